// ==== dsc_fabric_ctrl.sv ====
// Control and fabric clock block: serial-loaded configuration, divided and
// phase-shifted fabric clock, timer alignment and the timing violation flag.
// Assumes clk runs at twice the sampling rate (one tick = half a sampling
// period); all pins except clk and ce are asynchronous and are synchronised here.
module dsc_fabric_ctrl #(
    parameter int ALIGN_WAIT_CYCLES = dsc_pkg::ALIGN_DELAY_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Three-wire serial port and clear
    input wire logic serialClk,
    input wire logic serialLoad_b,
    input wire logic serialData,
    input wire logic portClear_b,
    // Timing pins
    input wire logic alignPulse,
    input wire logic inputCheckToggle,
    input wire dsc_pkg::dsc_clk_ctrl_s extClkCtrl,
    // Configuration outputs
    output logic [11:0] operatingConfig,
    output logic [9:0] gainCode,
    output logic [11:0] clockPhaseControl,
    // Fabric side
    output logic fabricClk,
    output logic dataStrobe,
    output logic timingViolationFlag
);
    // ------------------------------------------------------------
    // Elaboration checks and types
    // ------------------------------------------------------------
    if (ALIGN_WAIT_CYCLES < 1 || ALIGN_WAIT_CYCLES > 255) begin : g_bad_wait
        $error("ALIGN_WAIT_CYCLES must lie in 1..255");
    end

    localparam logic [7:0] WAIT_LAST = 8'(ALIGN_WAIT_CYCLES - 1);
    localparam int PIN_W = 10;
    // Idle levels: strobe and clear high, everything else low
    localparam logic [PIN_W-1:0] PIN_IDLE = 10'h0140;

    typedef enum logic [2:0] {
        TM_RUN = 3'b001,
        TM_HOLD = 3'b010,
        TM_WAIT = 3'b100
    } dsc_timer_state_e;

    function automatic logic [7:0] halfTicks(input logic mux2, input logic [1:0] ucr,
                                             input logic div2);
        logic [7:0] t;
        t = mux2 ? 8'h0004 : 8'h0008;
        if (ucr == dsc_pkg::UCR_BY2) begin
            t = t << 1;
        end else if (ucr == dsc_pkg::UCR_BY4) begin
            t = t << 2;
        end
        if (div2) begin
            t = t << 1;
        end
        return t;
    endfunction

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic rstMeta_reg;
    logic rstSync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_reg <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_b <= rstMeta_reg;
        end
    end

    logic [PIN_W-1:0] pinMeta_reg;
    logic [PIN_W-1:0] pinSync_reg;
    logic sclkLast_reg;

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            pinMeta_reg <= PIN_IDLE;
            pinSync_reg <= PIN_IDLE;
            sclkLast_reg <= 1'b0;
        end else if (ce) begin
            pinMeta_reg <= {serialClk, serialLoad_b, serialData, portClear_b, alignPulse,
                            inputCheckToggle, extClkCtrl};
            pinSync_reg <= pinMeta_reg;
            sclkLast_reg <= pinSync_reg[9];
        end
    end

    logic sclkRise;
    logic sldSync;
    logic sdataSync;
    logic clearSync_b;
    logic alignSync;
    logic checkSync;
    dsc_pkg::dsc_clk_ctrl_s extSync;

    assign sclkRise = pinSync_reg[9] && !sclkLast_reg;
    assign sldSync = pinSync_reg[8];
    assign sdataSync = pinSync_reg[7];
    assign clearSync_b = pinSync_reg[6];
    assign alignSync = pinSync_reg[5];
    assign checkSync = pinSync_reg[4];
    assign extSync = pinSync_reg[3:0];

    // ------------------------------------------------------------
    // Serial receiver and register file
    // ------------------------------------------------------------
    dsc_pkg::dsc_write_s wrWord;
    logic wrValid;

    dsc_serial_rx u_rx (
        .clk(clk),
        .rstSync_b(rstSync_b),
        .ce(ce),
        .sclkRise(sclkRise),
        .sldLevel(sldSync),
        .sdataLevel(sdataSync),
        .wrWord(wrWord),
        .wrValid(wrValid)
    );

    logic portClear;
    assign portClear = !clearSync_b && !sldSync;

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            operatingConfig <= dsc_pkg::RST_OPERATING_CONFIG;
            gainCode <= dsc_pkg::RST_GAIN_TRIM;
            clockPhaseControl <= dsc_pkg::RST_CLOCK_PHASE_CONTROL;
        end else if (ce) begin
            if (portClear) begin
                operatingConfig <= dsc_pkg::RST_OPERATING_CONFIG;
                gainCode <= dsc_pkg::RST_GAIN_TRIM;
                clockPhaseControl <= dsc_pkg::RST_CLOCK_PHASE_CONTROL;
            end else if (wrValid) begin
                // Unimplemented addresses fall through and change nothing
                case (wrWord.addr)
                    dsc_pkg::ADDR_OPERATING_CONFIG: operatingConfig <= wrWord.data;
                    dsc_pkg::ADDR_GAIN_TRIM: gainCode <= wrWord.data[9:0];
                    dsc_pkg::ADDR_CLOCK_PHASE_CONTROL: clockPhaseControl <= wrWord.data;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Effective clock settings
    // ------------------------------------------------------------
    logic mux2;
    logic [1:0] ucr;
    logic useExt;
    logic effDiv;
    logic [2:0] effPss;
    logic [7:0] half;
    logic [7:0] full;
    logic [7:0] dataMask;

    assign mux2 = operatingConfig[dsc_pkg::OPC_MUX_BIT];
    assign ucr = operatingConfig[dsc_pkg::OPC_UCR_LSB +: 2];
    assign useExt = operatingConfig[dsc_pkg::OPC_ECC_BIT];

    always_comb begin
        if (useExt) begin
            effDiv = extSync.outClockDivSel;
            effPss = extSync.phaseShiftSelect;
        end else begin
            effDiv = clockPhaseControl[dsc_pkg::CPC_DIV_BIT];
            effPss = clockPhaseControl[dsc_pkg::CPC_PSS_LSB +: 3];
        end
        if (mux2) begin
            effPss[2] = 1'b0;
        end
    end

    assign half = halfTicks(mux2, ucr, effDiv);
    assign full = half << 1;
    // Data period in ticks is half the undivided fabric period
    assign dataMask = halfTicks(mux2, ucr, 1'b0) - 8'h0001;

    // ------------------------------------------------------------
    // Timer, alignment and fabric clock
    // ------------------------------------------------------------
    dsc_timer_state_e tmState_reg;
    logic [7:0] waitCnt_reg;
    logic [7:0] divCnt_reg;

    // Power-on starts in the wait phase, exactly as after an align pulse
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            tmState_reg <= TM_WAIT;
            waitCnt_reg <= 8'h0000;
        end else if (ce) begin
            case (tmState_reg)
                TM_RUN: begin
                    if (alignSync) begin
                        tmState_reg <= TM_HOLD;
                    end
                end
                TM_HOLD: begin
                    waitCnt_reg <= 8'h0000;
                    if (!alignSync) begin
                        tmState_reg <= TM_WAIT;
                    end
                end
                TM_WAIT: begin
                    if (alignSync) begin
                        tmState_reg <= TM_HOLD;
                    end else if (waitCnt_reg == WAIT_LAST) begin
                        tmState_reg <= TM_RUN;
                    end else begin
                        waitCnt_reg <= waitCnt_reg + 8'h0001;
                    end
                end
                default: begin
                    tmState_reg <= TM_HOLD;
                end
            endcase
        end
    end

    logic running;
    logic [7:0] shifted;
    assign running = tmState_reg == TM_RUN;
    assign shifted = (divCnt_reg >= {5'h0000, effPss}) ? divCnt_reg - {5'h0000, effPss}
                   : divCnt_reg + full - {5'h0000, effPss};

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            divCnt_reg <= 8'h0000;
            fabricClk <= 1'b0;
            dataStrobe <= 1'b0;
        end else if (ce) begin
            if (!running) begin
                divCnt_reg <= 8'h0000;
                fabricClk <= 1'b0;
                dataStrobe <= 1'b0;
            end else begin
                // Wrap also covers a ratio shrinking under a running count
                divCnt_reg <= (divCnt_reg >= full - 8'h0001) ? 8'h0000 : divCnt_reg + 8'h0001;
                fabricClk <= shifted >= half;
                dataStrobe <= (divCnt_reg & dataMask) == 8'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Input check and violation flag
    // ------------------------------------------------------------
    // Samples one tick early and late, i.e. half a sampling period either side
    logic [2:0] checkHist_reg;

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            checkHist_reg <= 3'h0000;
            timingViolationFlag <= 1'b0;
        end else if (ce) begin
            checkHist_reg <= {checkHist_reg[1:0], checkSync};
            if (running && (divCnt_reg & dataMask) == 8'h0000) begin
                timingViolationFlag <= checkHist_reg[0] ^ checkHist_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_b);

    a_clear_loads_defaults: assert property (ce && portClear ##1 ce |->
        operatingConfig == 12'h0922 && gainCode == 10'h0200 && clockPhaseControl == 12'h0080)
        else $error("clear did not load defaults");
    a_gain_takes_low: assert property (ce && wrValid && !portClear && wrWord.addr == 4'h0001
        |=> gainCode == $past(wrWord.data[9:0]))
        else $error("gain write lost");
    a_unmapped_ignored: assert property (ce && wrValid && !portClear && wrWord.addr != 4'h0000
        && wrWord.addr != 4'h0001 && wrWord.addr != 4'h0005 |=> $stable(operatingConfig)
        && $stable(gainCode) && $stable(clockPhaseControl))
        else $error("unmapped address changed a register");
    a_hold_stops_clock: assert property (tmState_reg == TM_HOLD ##1 ce |-> !fabricClk)
        else $error("fabric clock ran during align");
    a_align_restart_zero: assert property (ce && tmState_reg == TM_HOLD && !alignSync
        |=> tmState_reg == TM_WAIT && divCnt_reg == 8'h0000)
        else $error("counter not restarted after align");
    a_short_mux_phase: assert property (mux2 |-> !effPss[2])
        else $error("upper phase bit used in 2:1 mode");
    a_strobe_spacing: assert property (ce && dataStrobe ##1 ce |-> !dataStrobe)
        else $error("data strobes back to back");
    a_flag_clear_match: assert property (ce && running && (divCnt_reg & dataMask) == 8'h0000
        && checkHist_reg[0] == checkHist_reg[2] |=> !timingViolationFlag)
        else $error("flag set with matching samples");
endmodule

// ==== dsc_pkg.sv ====
// Shared constants and types for the converter control and fabric clock block.
// Assumes a single 250 MHz core clock that stands for half a sampling period.
package dsc_pkg;
    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int ADDR_BITS = 4;
    localparam int DATA_BITS = 12;
    localparam logic [3:0] LAST_BIT_IDX = 4'h000f;

    // ------------------------------------------------------------
    // Register addresses and defaults
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_OPERATING_CONFIG = 4'h0000;
    localparam logic [3:0] ADDR_GAIN_TRIM = 4'h0001;
    localparam logic [3:0] ADDR_CLOCK_PHASE_CONTROL = 4'h0005;
    localparam logic [11:0] RST_OPERATING_CONFIG = 12'h0922;
    localparam logic [9:0] RST_GAIN_TRIM = 10'h0200;
    localparam logic [11:0] RST_CLOCK_PHASE_CONTROL = 12'h0080;
    localparam int GAIN_BITS = 10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OPC_MUX_BIT = 0;
    localparam int OPC_UCR_LSB = 3;
    localparam int OPC_ECC_BIT = 5;
    localparam int CPC_DIV_BIT = 0;
    localparam int CPC_PSS_LSB = 1;
    localparam int CPC_MDT_LSB = 5;
    localparam logic [1:0] UCR_BY2 = 2'h0002;
    localparam logic [1:0] UCR_BY4 = 2'h0003;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int ALIGN_DELAY_NS = 64;
    localparam int ALIGN_DELAY_CYCLES = (ALIGN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [11:0] data;
    } dsc_write_s;

    typedef struct packed {
        logic [2:0] phaseShiftSelect;
        logic outClockDivSel;
    } dsc_clk_ctrl_s;
endpackage

// ==== dsc_serial_rx.sv ====
// Three-wire write-only serial receiver: assembles address and data frames.
// Assumes serial inputs already synchronised and a one-cycle rising-edge pulse.
module dsc_serial_rx (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstSync_b,
    input wire logic ce,
    // Synchronised serial port
    input wire logic sclkRise,
    input wire logic sldLevel,
    input wire logic sdataLevel,
    // Completed frame
    output dsc_pkg::dsc_write_s wrWord,
    output logic wrValid
);
    typedef enum logic [2:0] {
        SR_IDLE = 3'b001,
        SR_SHIFT = 3'b010,
        SR_DONE = 3'b100
    } dsc_rx_state_e;

    dsc_rx_state_e state_reg;
    logic [3:0] bitCnt_reg;
    logic [14:0] shift_reg;
    logic takeBit;

    assign takeBit = ce && sclkRise && !sldLevel && state_reg != SR_DONE;

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            state_reg <= SR_IDLE;
            bitCnt_reg <= 4'h0000;
            shift_reg <= 15'h0000;
        end else if (ce && sclkRise) begin
            if (sldLevel) begin
                // Strobe high aborts any partial frame
                state_reg <= SR_IDLE;
                bitCnt_reg <= 4'h0000;
            end else begin
                case (state_reg)
                    SR_IDLE, SR_SHIFT: begin
                        shift_reg <= {shift_reg[13:0], sdataLevel};
                        bitCnt_reg <= bitCnt_reg + 4'h0001;
                        state_reg <= (bitCnt_reg == dsc_pkg::LAST_BIT_IDX) ? SR_DONE : SR_SHIFT;
                    end
                    SR_DONE: begin
                        state_reg <= SR_DONE;
                    end
                    default: begin
                        state_reg <= SR_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            wrValid <= 1'b0;
            wrWord <= '0;
        end else if (ce) begin
            wrValid <= takeBit && bitCnt_reg == dsc_pkg::LAST_BIT_IDX;
            wrWord <= {shift_reg, sdataLevel};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_b);

    a_frame_sixteen_bits: assert property (ce && wrValid |-> $past(bitCnt_reg) == 4'h000f)
        else $error("frame completed before sixteen bits");
    a_abort_resets_count: assert property (ce && sclkRise && sldLevel |=> bitCnt_reg == 4'h0000 && state_reg == SR_IDLE)
        else $error("strobe high did not abort frame");
    a_done_ignores_bits: assert property (ce && state_reg == SR_DONE && sclkRise && !sldLevel ##1 ce |-> !wrValid)
        else $error("extra clocks after frame produced a write");
endmodule

// ==== dsc_ctrl_model.sv ====
// Controller model that drives the three-wire write port from the far side.
// Assumes one caller at a time; paced from the core clock's falling edge.
module dsc_ctrl_model #(
    parameter int HALF_CYCLES = 125
) (
    // Pacing clock
    input wire logic clk,
    // Three-wire port
    output logic serialClk,
    output logic serialLoad_b,
    output logic serialData
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        serialClk = 1'b0;
        serialLoad_b = 1'b1;
        serialData = 1'b0;
    end

    // ----------------------------------------------------------------
    // Serial cycles
    // ----------------------------------------------------------------
    // Half period of 125 ticks plus one setup tick gives a 251-tick port period, just under 1 MHz
    task automatic tick(input logic ld, input logic d);
        @(negedge clk);
        serialLoad_b = ld;
        serialData = d;
        repeat (HALF_CYCLES) @(negedge clk);
        serialClk = 1'b1;
        repeat (HALF_CYCLES) @(negedge clk);
        serialClk = 1'b0;
    endtask

    // Fewer than 16 low cycles aborts; idle data shows the inverse, not a held bit
    task automatic send_frame(input logic [15:0] word, input int lowBits);
        for (int i = 0; i < lowBits; i++) begin
            tick(1'b0, (i < 16) ? word[15 - i] : ~serialData);
        end
        tick(1'b1, ~serialData);
    endtask

    task automatic hold_load(input logic ld);
        @(negedge clk);
        serialLoad_b = ld;
    endtask
endmodule

// ==== dsc_fabric_ctrl_tb_top.sv ====
// Self-checking bench for the control and fabric clock block.
// Assumes the controller model above and a 250 MHz core clock.
module dsc_fabric_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAITC = 4;
    logic clk = 1'b0;
    logic rst_b, ce, serialClk, serialLoad_b, serialData, portClear_b;
    logic alignPulse, fabricClk, dataStrobe, timingViolationFlag;
    logic inputCheckToggle = 1'b0;
    logic checkOn = 1'b0;
    logic fabLast = 1'b0;
    dsc_pkg::dsc_clk_ctrl_s extClkCtrl;
    logic [11:0] operatingConfig, clockPhaseControl;
    logic [9:0] gainCode;
    int fails = 0;
    int checked = 0;
    int expReg[16];
    int baseStrobe = -1;
    int phase0 = 0;

    always #2 clk = ~clk;

    // Data source side: check signal flips with every fabric clock edge, one per data word
    always @(negedge clk) begin
        if (checkOn && fabricClk !== fabLast) begin
            inputCheckToggle = ~inputCheckToggle;
        end
        fabLast = fabricClk;
    end

    dsc_fabric_ctrl #(.ALIGN_WAIT_CYCLES(WAITC)) uut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .serialClk(serialClk), .serialLoad_b(serialLoad_b), .serialData(serialData),
        .portClear_b(portClear_b), .alignPulse(alignPulse), .inputCheckToggle(inputCheckToggle),
        .extClkCtrl(extClkCtrl), .operatingConfig(operatingConfig), .gainCode(gainCode),
        .clockPhaseControl(clockPhaseControl), .fabricClk(fabricClk), .dataStrobe(dataStrobe),
        .timingViolationFlag(timingViolationFlag));
    dsc_ctrl_model ctrl (.clk(clk), .serialClk(serialClk), .serialLoad_b(serialLoad_b),
        .serialData(serialData));

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic set_defaults();
        expReg = '{default: 0};
        expReg[0] = 'h0922;
        expReg[1] = 'h0200;
        expReg[5] = 'h0080;
    endtask

    task automatic check_regs();
        check(operatingConfig, expReg[0] & 'h0fff, "operating config");
        check(gainCode, expReg[1] & 'h03ff, "gain code");
        check(clockPhaseControl, expReg[5] & 'h0fff, "phase control");
    endtask

    // Frames end with one high cycle, so calls in a row are back to back
    task automatic write_reg(input logic [3:0] addr, input logic [11:0] data, input int lowBits);
        ctrl.send_frame({addr, data}, lowBits);
        if (lowBits >= 16 && (addr == 4'h0 || addr == 4'h1 || addr == 4'h5)) begin
            expReg[addr] = int'(data);
        end
        check_regs();
    endtask

    // Align, then time strobes and fabric clock rises from the release
    task automatic measure(input int per, input int gap, output int phase);
        int lastRise, lastStrobe, nRise;
        logic prevClk;
        @(negedge clk);
        alignPulse = 1'b1;
        repeat (8) @(negedge clk);
        check(fabricClk, 1'b0, "fabric clock held");
        alignPulse = 1'b0;
        lastRise = -1;
        lastStrobe = -1;
        nRise = 0;
        prevClk = 1'b0;
        for (int t = 1; t < WAITC + 8 * per + 20; t++) begin
            @(posedge clk);
            #1;
            if (dataStrobe === 1'b1) begin
                if (baseStrobe < 0) begin
                    baseStrobe = t;
                end
                if (lastStrobe < 0) begin
                    check(t, baseStrobe, "restart delay");
                end else begin
                    check(t - lastStrobe, gap, "strobe spacing");
                end
                lastStrobe = t;
            end
            if (fabricClk === 1'b1 && prevClk === 1'b0) begin
                // First rise may come early from a shifted phase
                if (nRise > 1) begin
                    check(t - lastRise, per, "fabric period");
                end
                nRise++;
                lastRise = t;
            end
            prevClk = fabricClk;
        end
        phase = lastRise % per;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int ph, m;
        rst_b = 1'b0;
        ce = 1'b1;
        portClear_b = 1'b1;
        alignPulse = 1'b0;
        extClkCtrl = '0;
        set_defaults();
        ph = $urandom(24);
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        alignPulse = 1'b1;
        repeat (4) @(negedge clk);
        alignPulse = 1'b0;
        repeat (10) @(negedge clk);
        check_regs();
        write_reg(4'h1, 12'($urandom()), 16);
        write_reg(4'h5, 12'($urandom()), 16);
        write_reg(4'h2 + 4'($urandom() % 3), 12'($urandom()), 16);
        write_reg(4'h9, 12'($urandom()), 16);
        write_reg(4'h1, 12'h0fff, 10);
        write_reg(4'h5, 12'($urandom()), 20);
        write_reg(4'h1, 12'h03ff, 16);
        portClear_b = 1'b0;
        repeat (20) @(negedge clk);
        portClear_b = 1'b1;
        repeat (4) @(negedge clk);
        check_regs();
        ctrl.hold_load(1'b0);
        portClear_b = 1'b0;
        repeat (20) @(negedge clk);
        portClear_b = 1'b1;
        ctrl.hold_load(1'b1);
        set_defaults();
        repeat (4) @(negedge clk);
        check_regs();
        for (int mx = 0; mx < 2; mx++) begin
            for (int u = 0; u < 3; u++) begin
                m = (u == 0) ? 1 : 2 * u;
                write_reg(4'h0, 12'h0922 | 12'(((u == 0) ? 0 : u + 1) << 3) | 12'(mx), 16);
                for (int dv = 0; dv < 2; dv++) begin
                    extClkCtrl.outClockDivSel = dv[0];
                    measure(4 * (4 - 2 * mx) * m * (dv + 1), 2 * (4 - 2 * mx) * m, ph);
                end
            end
        end
        for (int mx = 0; mx < 2; mx++) begin
            write_reg(4'h0, 12'h0922 | 12'(mx), 16);
            for (int p = 0; p < 8; p++) begin
                extClkCtrl.phaseShiftSelect = 3'(p);
                extClkCtrl.outClockDivSel = 1'b0;
                measure(16 - 8 * mx, 8 - 4 * mx, ph);
                if (p == 0) begin
                    phase0 = ph;
                end
                check((ph - phase0 + 16) % (16 - 8 * mx), (mx == 1) ? p % 4 : p, "phase");
            end
        end
        repeat (100) @(negedge clk);
        check(timingViolationFlag, 1'b0, "flag with steady check");
        checkOn = 1'b1;
        repeat (100) @(negedge clk);
        check(timingViolationFlag, 1'b1, "flag with misplaced check");
        extClkCtrl.phaseShiftSelect = extClkCtrl.phaseShiftSelect + 3'h2;
        repeat (100) @(negedge clk);
        check(timingViolationFlag, 1'b0, "flag cleared");
        checkOn = 1'b0;
        extClkCtrl = '0;
        write_reg(4'h0, 12'h0902, 16);
        write_reg(4'h5, 12'h0081, 16);
        measure(32, 8, ph);
        print_verdict();
    end

    // Tests need about 80000 cycles
    initial begin
        repeat (95000) @(posedge clk);
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
